// [cclu_regs.vh]
`ifndef CCLU_REGS_VH
`define CCLU_REGS_VH

// register indexes; byte address is four times the index
`define CCLU_IDX_CTRL 4'h0
`define CCLU_IDX_SEQ 4'h1
`define CCLU_IDX_A0 4'h5
`define CCLU_IDX_B0 4'h6
`define CCLU_IDX_C0 4'h7
`define CCLU_IDX_T0 4'h8
`define CCLU_IDX_A1 4'h9
`define CCLU_IDX_B1 4'hA
`define CCLU_IDX_C1 4'hB
`define CCLU_IDX_T1 4'hC

`define CCLU_RST_VAL 8'h00
`define CCLU_MASK_CTRL 8'h41
`define CCLU_MASK_SEQ 8'h0F
`define CCLU_MASK_TA 8'hF9
`define CCLU_MASK_TC 8'h0F

`define CCLU_BIT_EN 0
`define CCLU_BIT_RUNSTBY 6
`define CCLU_BIT_EDGE 7
`define CCLU_BIT_CLOCK_SOURCE_SELECT 6
`define CCLU_FILT_HI 5
`define CCLU_FILT_LO 4
`define CCLU_BIT_PIN_OUTPUT_ENABLE 3

`define CCLU_SEQ_OFF 4'h0
`define CCLU_SEQ_DFF 4'h1
`define CCLU_SEQ_JK 4'h2
`define CCLU_SEQ_GATED_D_LATCH_MODE 4'h3
`define CCLU_SEQ_RS 4'h4

`define CCLU_FILT_NONE 2'h0
`define CCLU_FILT_SYNC 2'h1
`define CCLU_FILT_FILT 2'h2

`define CCLU_SRC_MASK 4'h0
`define CCLU_SRC_FEEDBACK 4'h1
`define CCLU_SRC_LINK 4'h2
`define CCLU_SRC_EVENT0 4'h3
`define CCLU_SRC_EVENT1 4'h4
`define CCLU_SRC_PIN 4'h5
`define CCLU_SRC_PER0 4'h6
`define CCLU_SRC_PERLAST 4'hE
`endif

// [cclu_tbl_stage.v]
`timescale 1ns/1ns
`include "cclu_regs.vh"
module cclu_tbl_stage (
  input  wire       i_mclk,
  input  wire       i_rst,
  input  wire       i_run,
  input  wire       i_tick,
  input  wire [2:0] i_in,
  input  wire [7:0] i_truth,
  input  wire [1:0] i_filt,
  input  wire       i_edge,
  output reg        o_out
);
  reg  [3:0] sh_r;
  reg        filt_r;
  reg        prev_r;
  reg        fval;
  wire       raw;

  assign raw = i_truth[i_in];

  // internal state clears one cycle after the table is disabled
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sh_r   <= 4'h0;
      filt_r <= 1'b0;
      prev_r <= 1'b0;
    end else if (!i_run) begin
      sh_r   <= 4'h0;
      filt_r <= 1'b0;
      prev_r <= 1'b0;
    end else if (i_tick) begin
      sh_r <= {sh_r[2:0], raw};
      // three equal samples needed; delay is four to five ticks
      if (sh_r[3] == sh_r[2] && sh_r[2] == sh_r[1])
        filt_r <= sh_r[3];
      prev_r <= fval;
    end
  end

  always @* begin
    case (i_filt)
      `CCLU_FILT_SYNC: fval = sh_r[1];
      `CCLU_FILT_FILT: fval = filt_r;
      default:         fval = raw;
    endcase
  end

  always @* begin
    if (!i_run)
      o_out = 1'b0;
    else if (i_edge)
      o_out = fval & ~prev_r;
    else
      o_out = fval;
  end
endmodule

// [cclu_seq_unit.v]
`timescale 1ns/1ns
`include "cclu_regs.vh"
module cclu_seq_unit #(
  parameter PER_W = 9
) (
  input  wire               i_mclk,
  input  wire               i_rst,
  input  wire               i_wb_cyc,
  input  wire               i_wb_stb,
  input  wire               i_wb_we,
  input  wire [5:0]         i_wb_adr,
  input  wire [3:0]         i_wb_sel,
  input  wire [31:0]        i_wb_dat,
  output wire [31:0]        o_wb_dat,
  output wire               o_wb_ack,
  input  wire [1:0]         i_evt,
  input  wire [2:0]         i_tbl0_pin,
  input  wire [2:0]         i_tbl1_pin,
  input  wire [3*PER_W-1:0] i_tbl0_per,
  input  wire [3*PER_W-1:0] i_tbl1_per,
  input  wire               i_standby,
  output wire [1:0]         o_tbl_event,
  output wire [1:0]         o_tbl_pin,
  output wire [1:0]         o_tbl_pin_oe
);
  localparam EXT_W = 1 + 2 + 6 + 6 * PER_W;

  reg  [7:0]       pctl_r;
  reg  [7:0]       seqc_r;
  reg  [7:0]       ta0_r;
  reg  [7:0]       tb0_r;
  reg  [7:0]       tc0_r;
  reg  [7:0]       tt0_r;
  reg  [7:0]       ta1_r;
  reg  [7:0]       tb1_r;
  reg  [7:0]       tc1_r;
  reg  [7:0]       tt1_r;
  reg              ack_r;
  reg  [31:0]      dat_r;
  reg  [7:0]       rd_val;
  reg  [EXT_W-1:0] s1_r;
  reg  [EXT_W-1:0] s2_r;
  reg  [1:0]       in2p_r;
  reg              seq_r;
  reg              seq_nxt;
  reg              clr_hold_r;
  reg  [1:0]       ev_r;
  reg  [1:0]       pin_r;
  reg  [1:0]       oe_r;

  wire             bus_req;
  wire [3:0]       idx;
  wire             bus_wr;
  wire [7:0]       wdat;
  wire             stby;
  wire [1:0]       evs;
  wire [2:0]       pin0;
  wire [2:0]       pin1;
  wire [3*PER_W-1:0] per0;
  wire [3*PER_W-1:0] per1;
  wire             pen;
  wire             pstop;
  wire             run0;
  wire             run1;
  wire             ck0;
  wire             ck1;
  wire             seq_on;
  wire             seq_q;
  wire             even_dis;
  wire [2:0]       in0;
  wire [2:0]       in1;
  wire             rise0;
  wire             rise1;
  wire             tick0;
  wire             tick1;
  wire             st0;
  wire             st1;
  wire             need0;
  wire             need1;
  wire             out0;
  wire             out1;

  // input source mux for one table line
  function pick;
    input [3:0]       sel;
    input             fb;
    input             lnk;
    input [1:0]       ev;
    input             pin;
    input [PER_W-1:0] per;
    reg   [3:0]       k;
    begin
      k = sel - `CCLU_SRC_PER0;
      case (sel)
        `CCLU_SRC_MASK:     pick = 1'b0;
        `CCLU_SRC_FEEDBACK: pick = fb;
        `CCLU_SRC_LINK:     pick = lnk;
        `CCLU_SRC_EVENT0:   pick = ev[0];
        `CCLU_SRC_EVENT1:   pick = ev[1];
        `CCLU_SRC_PIN:      pick = pin;
        default: begin
          if (sel >= `CCLU_SRC_PER0 && sel <= `CCLU_SRC_PERLAST &&
              k < PER_W)
            pick = per[k];
          else
            pick = 1'b0;
        end
      endcase
    end
  endfunction

  // tables that use clocked logic need the peripheral clock
  function needs_pclk;
    input [7:0] ta;
    input       seqon;
    begin
      needs_pclk = (ta[`CCLU_FILT_HI:`CCLU_FILT_LO] != `CCLU_FILT_NONE)
                   | ta[`CCLU_BIT_EDGE] | seqon;
    end
  endfunction

  // ---------------- bus slave ----------------
  assign bus_req  = i_wb_cyc & i_wb_stb;
  assign idx      = i_wb_adr[5:2];
  assign wdat     = i_wb_dat[7:0];
  // write lands on the edge where the master sees ack
  assign bus_wr   = bus_req & i_wb_we & ack_r & i_wb_sel[0];
  assign o_wb_ack = ack_r;
  assign o_wb_dat = dat_r;

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req & ~ack_r;
      if (bus_req & ~ack_r)
        dat_r <= {24'h00_0000, rd_val};
      else
        dat_r <= 32'h0000_0000;
    end
  end

  always @* begin
    case (idx)
      `CCLU_IDX_CTRL: rd_val = pctl_r;
      `CCLU_IDX_SEQ:  rd_val = seqc_r;
      `CCLU_IDX_A0:   rd_val = ta0_r;
      `CCLU_IDX_B0:   rd_val = tb0_r;
      `CCLU_IDX_C0:   rd_val = tc0_r;
      `CCLU_IDX_T0:   rd_val = tt0_r;
      `CCLU_IDX_A1:   rd_val = ta1_r;
      `CCLU_IDX_B1:   rd_val = tb1_r;
      `CCLU_IDX_C1:   rd_val = tc1_r;
      `CCLU_IDX_T1:   rd_val = tt1_r;
      default:        rd_val = 8'h00;
    endcase
  end

  // protected fields change only while their table is disabled;
  // they may be written together with enable going high
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pctl_r <= `CCLU_RST_VAL;
      seqc_r <= `CCLU_RST_VAL;
      ta0_r  <= `CCLU_RST_VAL;
      tb0_r  <= `CCLU_RST_VAL;
      tc0_r  <= `CCLU_RST_VAL;
      tt0_r  <= `CCLU_RST_VAL;
      ta1_r  <= `CCLU_RST_VAL;
      tb1_r  <= `CCLU_RST_VAL;
      tc1_r  <= `CCLU_RST_VAL;
      tt1_r  <= `CCLU_RST_VAL;
    end else if (bus_wr) begin
      case (idx)
        `CCLU_IDX_CTRL: pctl_r <= wdat & `CCLU_MASK_CTRL;
        `CCLU_IDX_SEQ: begin
          if (!ta0_r[`CCLU_BIT_EN])
            seqc_r <= wdat & `CCLU_MASK_SEQ;
        end
        `CCLU_IDX_A0: begin
          if (ta0_r[`CCLU_BIT_EN])
            ta0_r <= {ta0_r[7:1], wdat[0]};
          else
            ta0_r <= wdat & `CCLU_MASK_TA;
        end
        `CCLU_IDX_B0: begin
          if (!ta0_r[`CCLU_BIT_EN])
            tb0_r <= wdat;
        end
        `CCLU_IDX_C0: begin
          if (!ta0_r[`CCLU_BIT_EN])
            tc0_r <= wdat & `CCLU_MASK_TC;
        end
        `CCLU_IDX_T0: begin
          if (!ta0_r[`CCLU_BIT_EN])
            tt0_r <= wdat;
        end
        `CCLU_IDX_A1: begin
          if (ta1_r[`CCLU_BIT_EN])
            ta1_r <= {ta1_r[7:1], wdat[0]};
          else
            ta1_r <= wdat & `CCLU_MASK_TA;
        end
        `CCLU_IDX_B1: begin
          if (!ta1_r[`CCLU_BIT_EN])
            tb1_r <= wdat;
        end
        `CCLU_IDX_C1: begin
          if (!ta1_r[`CCLU_BIT_EN])
            tc1_r <= wdat & `CCLU_MASK_TC;
        end
        `CCLU_IDX_T1: begin
          if (!ta1_r[`CCLU_BIT_EN])
            tt1_r <= wdat;
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------- input synchronisers ----------------
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s1_r <= {EXT_W{1'b0}};
      s2_r <= {EXT_W{1'b0}};
    end else begin
      s1_r <= {i_standby, i_evt, i_tbl0_pin, i_tbl1_pin,
               i_tbl0_per, i_tbl1_per};
      s2_r <= s1_r;
    end
  end

  assign {stby, evs, pin0, pin1, per0, per1} = s2_r;

  // ---------------- enables and clocking ----------------
  assign pen      = pctl_r[`CCLU_BIT_EN];
  // peripheral clock is gone in standby unless run bit is set
  assign pstop    = stby & ~pctl_r[`CCLU_BIT_RUNSTBY];
  assign run0     = pen & ta0_r[`CCLU_BIT_EN];
  assign run1     = pen & ta1_r[`CCLU_BIT_EN];
  assign ck0      = ta0_r[`CCLU_BIT_CLOCK_SOURCE_SELECT];
  assign ck1      = ta1_r[`CCLU_BIT_CLOCK_SOURCE_SELECT];
  assign even_dis = ~run0;

  // feedback and link read registered outputs, which breaks
  // the loop two linked tables would otherwise form
  assign in0[0] = pick(tb0_r[3:0], seq_q, ev_r[1], evs, pin0[0],
                       per0[0 +: PER_W]);
  assign in0[1] = pick(tb0_r[7:4], seq_q, ev_r[1], evs, pin0[1],
                       per0[PER_W +: PER_W]);
  assign in0[2] = pick(tc0_r[3:0], seq_q, ev_r[1], evs, pin0[2],
                       per0[2*PER_W +: PER_W]);
  assign in1[0] = pick(tb1_r[3:0], seq_q, ev_r[0], evs, pin1[0],
                       per1[0 +: PER_W]);
  assign in1[1] = pick(tb1_r[7:4], seq_q, ev_r[0], evs, pin1[1],
                       per1[PER_W +: PER_W]);
  assign in1[2] = pick(tc1_r[3:0], seq_q, ev_r[0], evs, pin1[2],
                       per1[2*PER_W +: PER_W]);

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst)
      in2p_r <= 2'b00;
    else
      in2p_r <= {in1[2], in0[2]};
  end

  assign rise0 = in0[2] & ~in2p_r[0];
  assign rise1 = in1[2] & ~in2p_r[1];
  // line 2 edges keep clocking in any sleep mode
  assign tick0 = run0 & (ck0 ? rise0 : ~pstop);
  assign tick1 = run1 & (ck1 ? rise1 : ~pstop);

  cclu_tbl_stage u_stage0 (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_run   (run0),
    .i_tick  (tick0),
    .i_in    ({in0[2] & ~ck0, in0[1:0]}),
    .i_truth (tt0_r),
    .i_filt  (ta0_r[`CCLU_FILT_HI:`CCLU_FILT_LO]),
    .i_edge  (ta0_r[`CCLU_BIT_EDGE]),
    .o_out   (st0)
  );

  cclu_tbl_stage u_stage1 (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_run   (run1),
    .i_tick  (tick1),
    .i_in    ({in1[2] & ~ck1, in1[1:0]}),
    .i_truth (tt1_r),
    .i_filt  (ta1_r[`CCLU_FILT_HI:`CCLU_FILT_LO]),
    .i_edge  (ta1_r[`CCLU_BIT_EDGE]),
    .o_out   (st1)
  );

  // ---------------- sequential element ----------------
  assign seq_on = (seqc_r[3:0] >= `CCLU_SEQ_DFF) &&
                  (seqc_r[3:0] <= `CCLU_SEQ_RS);
  // disabled even table clears the element at once
  assign seq_q  = even_dis ? 1'b0 : seq_r;

  always @* begin
    case (seqc_r[3:0])
      `CCLU_SEQ_DFF:
        seq_nxt = st1 ? st0 : seq_r;
      `CCLU_SEQ_JK: begin
        case ({st0, st1})
          2'b01:   seq_nxt = 1'b0;
          2'b10:   seq_nxt = 1'b1;
          2'b11:   seq_nxt = ~seq_r;
          default: seq_nxt = seq_r;
        endcase
      end
      `CCLU_SEQ_GATED_D_LATCH_MODE:
        seq_nxt = st1 ? st0 : seq_r;
      `CCLU_SEQ_RS: begin
        case ({st0, st1})
          2'b01:   seq_nxt = 1'b0;
          2'b10:   seq_nxt = 1'b1;
          default: seq_nxt = seq_r;
        endcase
      end
      default: seq_nxt = 1'b0;
    endcase
  end

  // element runs on the even table's tick, also when the odd
  // table picks a different clock source
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      seq_r      <= 1'b0;
      clr_hold_r <= 1'b0;
    end else begin
      clr_hold_r <= even_dis;
      if (even_dis | clr_hold_r)
        seq_r <= 1'b0;
      else if (tick0)
        seq_r <= seq_nxt;
    end
  end

  // ---------------- outputs ----------------
  assign need0 = needs_pclk(ta0_r, seq_on);
  assign need1 = needs_pclk(ta1_r, seq_on);
  assign out0  = (pstop & ~ck0 & need0) ? 1'b0 :
                 (seq_on ? seq_q : st0);
  assign out1  = (pstop & ~ck1 & need1) ? 1'b0 : st1;

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ev_r  <= 2'b00;
      pin_r <= 2'b00;
      oe_r  <= 2'b00;
    end else begin
      ev_r  <= {out1, out0};
      pin_r <= {out1, out0};
      oe_r  <= {run1 & ta1_r[`CCLU_BIT_PIN_OUTPUT_ENABLE],
                run0 & ta0_r[`CCLU_BIT_PIN_OUTPUT_ENABLE]};
    end
  end

  assign o_tbl_event  = ev_r;
  assign o_tbl_pin    = pin_r;
  assign o_tbl_pin_oe = oe_r;
endmodule

// [cclu_seq_unit_assertions.sv]
`timescale 1ns/1ns
`include "cclu_regs.vh"
module cclu_seq_unit_checker (
  input logic        i_mclk,
  input logic        i_rst,
  input logic        i_wb_cyc,
  input logic        i_wb_stb,
  input logic        i_wb_we,
  input logic [5:0]  i_wb_adr,
  input logic [3:0]  i_wb_sel,
  input logic [31:0] i_wb_dat,
  input logic [31:0] o_wb_dat,
  input logic        o_wb_ack,
  input logic [1:0]  o_tbl_event,
  input logic [1:0]  o_tbl_pin,
  input logic [1:0]  o_tbl_pin_oe
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic       wr;
  logic       oe_ok;
  logic [3:0] idx;
  logic [7:0] ctl_r, seq_r, a0_r;
  assign wr = o_wb_ack && i_wb_we && i_wb_sel[0];
  assign idx = i_wb_adr[5:2];
  assign oe_ok = ctl_r[0] && a0_r[3] && a0_r[0];
  // shadows follow the write that takes effect at the acked edge
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ctl_r <= 8'h00;
      seq_r <= 8'h00;
      a0_r <= 8'h00;
    end else if (wr) begin
      if (idx == `CCLU_IDX_CTRL)
        ctl_r <= i_wb_dat[7:0] & `CCLU_MASK_CTRL;
      if (idx == `CCLU_IDX_SEQ && !a0_r[0])
        seq_r <= i_wb_dat[7:0] & `CCLU_MASK_SEQ;
      if (idx == `CCLU_IDX_A0)
        a0_r <= a0_r[0] ? {a0_r[7:1], i_wb_dat[0]}
                        : i_wb_dat[7:0] & `CCLU_MASK_TA;
    end
  end
  sequence s_rd(int i);
    o_wb_ack && !i_wb_we && idx == i;
  endsequence
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  property p_ack; s_req |=> o_wb_ack ##1 !o_wb_ack; endproperty
  property p_off; !ctl_r[0] [*3] |-> o_tbl_event == 2'h0; endproperty
  property p_pin;
    !ctl_r[0] [*3] |-> o_tbl_pin == 2'h0 && o_tbl_pin_oe == 2'h0;
  endproperty
  property p_oe; o_tbl_pin_oe[0] |-> oe_ok || $past(oe_ok); endproperty
  property p_ctl; s_rd(0) |-> o_wb_dat == {24'h0, ctl_r}; endproperty
  property p_seq; s_rd(1) |-> o_wb_dat == {24'h0, seq_r}; endproperty
  property p_a0; s_rd(5) |-> o_wb_dat == {24'h0, a0_r}; endproperty
  property p_hole;
    o_wb_ack && !i_wb_we && (idx inside {2, 3, 4} || idx > 12)
      |-> o_wb_dat == 32'h0;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle");
  a_off: assert property (p_off) else $error("output while off");
  a_pin: assert property (p_pin) else $error("pin or oe while off");
  a_oe: assert property (p_oe) else $error("oe without enable");
  a_ctl: assert property (p_ctl) else $error("ctrl readback");
  a_seq: assert property (p_seq) else $error("seq readback");
  a_a0: assert property (p_a0) else $error("table a readback");
  a_hole: assert property (p_hole) else $error("hole not zero");
endmodule

// [cclu_far_side.sv]
`timescale 1ns/1ns
module cclu_far_side (
  input  logic       i_mclk,
  input  logic       i_rst,
  input  logic [2:0] i_lvl0,
  input  logic [2:0] i_lvl1,
  output logic [2:0] o_pin0,
  output logic [2:0] o_pin1
);
  // pin drivers move only after an edge, like outside logic would
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_pin0 <= 3'h0;
      o_pin1 <= 3'h0;
    end else begin
      o_pin0 <= i_lvl0;
      o_pin1 <= i_lvl1;
    end
  end
endmodule

// [tb_cclu_seq_unit.sv]
`timescale 1ns/1ns
module tb_cclu_seq_unit;
  logic        clk, rst, cyc, stb, we, stby, prv, ack;
  logic [3:0]  sel;
  logic [5:0]  adr;
  logic [31:0] wdat, rdat;
  logic [2:0]  lvl0, lvl1, pin0, pin1;
  logic [1:0]  ev, opin, oe;
  logic [7:0]  q;
  logic [11:0] pat [0:5];
  int          failures, checked;
  localparam logic [7:0] TT = 8'hB4;

  cclu_seq_unit cclu_seq_unit_i (
    .i_mclk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_evt(2'h0),
    .i_tbl0_pin(pin0), .i_tbl1_pin(pin1), .i_tbl0_per(27'h0),
    .i_tbl1_per(27'h0), .i_standby(stby), .o_tbl_event(ev),
    .o_tbl_pin(opin), .o_tbl_pin_oe(oe));
  cclu_far_side cclu_far_side_i (.i_mclk(clk), .i_rst(rst),
    .i_lvl0(lvl0), .i_lvl1(lvl1), .o_pin0(pin0), .o_pin1(pin1));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task wrap_up;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input string nm, input [7:0] s, input [7:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask

  // waits for ack under a bound; a lost ack ends the run
  task wb(input [5:0] a, input w, input [7:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= a;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    if (n >= 20) begin
      failures++;
      wrap_up();
    end
  endtask

  task rc(input [5:0] a, input [7:0] e, input string nm);
    wb(a, 1'b0, 8'h00);
    chk(nm, q, e);
  endtask

  // two sync flops, table register and element tick fit in eight
  task st(input [2:0] a, input [2:0] b);
    lvl0 <= a;
    lvl1 <= b;
    repeat (8) @(posedge clk);
  endtask

  task t_regs;
    rc(6'h00, 8'h00, "ctrl rst");
    rc(6'h14, 8'h00, "a0 rst");
    wb(6'h00, 1'b1, 8'hFF);
    rc(6'h00, 8'h41, "ctrl mask");
    wb(6'h04, 1'b1, 8'hFF);
    rc(6'h04, 8'h0F, "seq mask");
    wb(6'h24, 1'b1, 8'hFE);
    rc(6'h24, 8'hF8, "a1 mask");
    rc(6'h08, 8'h00, "hole");
    wb(6'h24, 1'b1, 8'h00);
    $display("test regs done");
  endtask

  task t_prot;
    wb(6'h04, 1'b1, 8'h00);
    wb(6'h14, 1'b1, 8'h01);
    wb(6'h04, 1'b1, 8'h02);
    rc(6'h04, 8'h00, "seq locked");
    wb(6'h14, 1'b1, 8'h39);
    rc(6'h14, 8'h01, "a0 locked");
    wb(6'h14, 1'b1, 8'h00);
    $display("test prot done");
  endtask

  task t_lut;
    wb(6'h18, 1'b1, 8'h55);
    wb(6'h1C, 1'b1, 8'h05);
    wb(6'h20, 1'b1, TT);
    wb(6'h00, 1'b1, 8'h01);
    wb(6'h14, 1'b1, 8'h09);
    for (int v = 0; v < 8; v++) begin
      st(v[2:0], 3'h0);
      chk("lut", {7'h0, ev[0]}, {7'h0, TT[v]});
      chk("pin", {7'h0, opin[0]}, {7'h0, TT[v]});
    end
    chk("oe", {6'h0, oe}, 8'h01);
    wb(6'h00, 1'b1, 8'h00);
    repeat (4) @(posedge clk);
    chk("off", {6'h0, ev}, 8'h00);
    wb(6'h00, 1'b1, 8'h01);
    $display("test lut done");
  endtask

  task t_seq;
    wb(6'h14, 1'b1, 8'h00);
    wb(6'h18, 1'b1, 8'h05);
    wb(6'h1C, 1'b1, 8'h00);
    wb(6'h20, 1'b1, 8'hAA);
    wb(6'h28, 1'b1, 8'h05);
    wb(6'h30, 1'b1, 8'hAA);
    wb(6'h24, 1'b1, 8'h01);
    for (int m = 0; m < 6; m++) begin
      st(3'h0, 3'h0);
      wb(6'h14, 1'b1, 8'h00);
      wb(6'h04, 1'b1, m[7:0]);
      wb(6'h14, 1'b1, 8'h01);
      st(3'h0, 3'h0);
      chk("clear", {7'h0, ev[0]}, 8'h00);
      for (int s = 3; s >= 0; s--) begin
        st({2'h0, pat[m][3*s+2]}, {2'h0, pat[m][3*s+1]});
        chk("step", {7'h0, ev[0]}, {7'h0, pat[m][3*s]});
        chk("odd", {7'h0, ev[1]}, {7'h0, pat[m][3*s+1]});
      end
      if (m == 2) begin
        st(3'h1, 3'h1);
        @(negedge clk);
        prv = ev[0];
        @(negedge clk);
        chk("toggle", {7'h0, ev[0]}, {7'h0, ~prv});
        @(posedge clk);
      end
    end
    $display("test seq done");
  endtask

  task t_stby;
    wb(6'h14, 1'b1, 8'h00);
    wb(6'h04, 1'b1, 8'h01);
    wb(6'h14, 1'b1, 8'h01);
    st(3'h1, 3'h1);
    stby <= 1'b1;
    repeat (8) @(posedge clk);
    chk("stby low", {7'h0, ev[0]}, 8'h00);
    stby <= 1'b0;
    wb(6'h00, 1'b1, 8'h41);
    stby <= 1'b1;
    repeat (8) @(posedge clk);
    chk("stby run", {7'h0, ev[0]}, 8'h01);
    stby <= 1'b0;
    $display("test stby done");
  endtask

  // line 2 clocks the element; the block is stopped before the change
  task t_clk;
    int n;
    wb(6'h00, 1'b1, 8'h00);
    wb(6'h14, 1'b1, 8'h00);
    wb(6'h1C, 1'b1, 8'h05);
    wb(6'h20, 1'b1, 8'h5A);
    wb(6'h14, 1'b1, 8'h41);
    wb(6'h00, 1'b1, 8'h01);
    st(3'h1, 3'h1);
    chk("no line edge", {7'h0, ev[0]}, 8'h00);
    st(3'h5, 3'h1);
    chk("line edge", {7'h0, ev[0]}, 8'h01);
    st(3'h4, 3'h1);
    chk("line high", {7'h0, ev[0]}, 8'h01);
    st(3'h0, 3'h1);
    st(3'h4, 3'h1);
    chk("line edge 0", {7'h0, ev[0]}, 8'h00);
    // odd table: synchroniser plus edge detect gives one pulse
    wb(6'h24, 1'b1, 8'h00);
    wb(6'h24, 1'b1, 8'h91);
    st(3'h0, 3'h0);
    lvl1 <= 3'h1;
    n = 0;
    repeat (10) begin
      @(negedge clk);
      if (ev[1] === 1'b1)
        n++;
    end
    chk("edge pulse", n[7:0], 8'h01);
    $display("test clk done");
  endtask

  initial begin
    rst = 1'b1;
    {cyc, stb, we, stby} = 4'h0;
    sel = 4'h0;
    adr = 6'h00;
    wdat = 32'h0;
    lvl0 = 3'h0;
    lvl1 = 3'h0;
    failures = 0;
    checked = 0;
    // steps of three bits: even input, odd input, expected element
    pat[0] = 12'b101010111000;
    pat[1] = 12'b010100111001;
    pat[2] = 12'b101010000101;
    pat[3] = 12'b010100111001;
    pat[4] = 12'b101010110101;
    pat[5] = 12'b101010111000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_prot();
    t_lut();
    t_seq();
    t_stby();
    t_clk();
    wrap_up();
  end
endmodule

bind cclu_seq_unit cclu_seq_unit_checker cclu_seq_unit_checker_i (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .o_tbl_event(o_tbl_event),
  .o_tbl_pin(o_tbl_pin), .o_tbl_pin_oe(o_tbl_pin_oe));
